// ==== core/cbc_top.sv ====
// Purpose: Command and bus ownership control registers
// Assumes: Register port driven by logic on core_clk
// Notes:   Read data is registered, valid one cycle after reg_rd
`timescale 1ns/1ps
`include "cbc_consts.svh"
module cbc_top (
  input  wire logic            core_clk,          // 100 MHz system clock
  input  wire logic            reset_n,           // Async reset, active low
  input  wire logic [6:0]      reg_addr,          // Register address
  input  wire logic            reg_wr,            // Write strobe
  input  wire logic            reg_rd,            // Read strobe
  input  wire logic [7:0]      reg_wdata,         // Write data
  input  wire logic            cmd_done_in,       // Command engine done
  output logic [7:0]           reg_rdata,         // Read data
  output logic                 chip_powerdown,    // Whole-chip power-down
  output logic                 rf_frontend_powerdown, // Rx/Tx power-down
  output cbc_pkg::cbc_cmd_type cmd_code,          // Running command code
  output logic                 cmd_start,         // Command launch pulse
  output logic                 cmd_busy,          // Command in progress
  output logic                 host_if_enable,    // Host port owns bus
  output logic                 sam_if_enable,     // Module port owns bus
  output cbc_pkg::cbc_link_type secure_module_link_select // Link protocol
);
  import cbc_pkg::*;

  // Stored register state
  logic        standby_q;                 // Power-down request
  logic        rf_off_q;                  // Front-end power-down
  cbc_cmd_type code_q;                    // Command field
  logic        grant_write_unlock_q;      // Grant unlock
  logic        host_port_bus_grant_q;     // Host grant
  logic        secure_module_bus_grant_q; // Module grant
  cbc_link_type link_q;                   // Link select
  logic        start_q;                   // Launch pulse
  logic        busy_q;                    // Registered busy
  logic [7:0]  rdata_q;                   // Read data register

  // Decoded accesses
  logic        wr_cmd;                    // Write to command register
  logic        wr_bus;                    // Write to ownership register
  logic        want_host;                 // Write asks for host grant
  logic        want_sam;                  // Write asks for module grant
  logic        grant_ok;                  // Grant change is legal
  cbc_cmd_type wr_code;                   // Code in the write data

  cbc_cmd_if   cmd ();                    // Sequencer link

  assign wr_cmd    = reg_wr && (reg_addr == `CBC_OFS_COMMAND);
  assign wr_bus    = reg_wr && (reg_addr == `CBC_OFS_BUS_OWN);
  assign want_host = reg_wdata[`CBC_BUS_HOST_BIT];
  assign want_sam  = reg_wdata[`CBC_BUS_SAM_BIT];
  assign wr_code   = reg_wdata[`CBC_CMD_CODE_MSB:`CBC_CMD_CODE_LSB];

  // Grants move only when unlocked and not both requested
  assign grant_ok  = grant_write_unlock_q && !(want_host && want_sam);

  // Launch or abort requests toward the sequencer
  assign cmd.start = start_q;
  assign cmd.stop  = wr_cmd && (wr_code == `CBC_CMD_IDLE) && cmd.busy;
  assign cmd.code  = code_q;

  // Command sequencer
  cbc_cmd_seq u_seq (
    .core_clk    (core_clk),
    .reset_n     (reset_n),
    .cmd_done_in (cmd_done_in),
    .cmd         (cmd)
  );

  // Power controls, plain software bits
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      standby_q <= 1'b0;
      rf_off_q  <= 1'b0;
    end else if (wr_cmd) begin
      standby_q <= reg_wdata[`CBC_CMD_STANDBY_BIT];
      rf_off_q  <= reg_wdata[`CBC_CMD_RF_OFF_BIT];
    end
  end

  // Command field, software write wins over finish
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      code_q <= `CBC_CMD_IDLE;
    end else if (wr_cmd) begin
      code_q <= wr_code;
    end else if (cmd.finish) begin
      code_q <= `CBC_CMD_IDLE;
    end
  end

  // Launch pulse one cycle after a non-idle code write
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      start_q <= 1'b0;
    end else begin
      start_q <= wr_cmd && (wr_code != `CBC_CMD_IDLE);
    end
  end

  // Registered busy for the output
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= cmd.busy;
    end
  end

  // Unlock bit, consumed by the next write
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      grant_write_unlock_q <= 1'b0;
    end else if (reg_wr && grant_write_unlock_q) begin
      grant_write_unlock_q <= 1'b0;
    end else if (wr_bus) begin
      grant_write_unlock_q <= reg_wdata[`CBC_BUS_UNLOCK_BIT];
    end
  end

  // Bus grants, changed only through an unlocked write
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      host_port_bus_grant_q     <= 1'b0;
      secure_module_bus_grant_q <= 1'b0;
    end else if (wr_bus && grant_ok) begin
      host_port_bus_grant_q     <= want_host;
      secure_module_bus_grant_q <= want_sam;
    end
  end

  // Link protocol select, plain software field
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      link_q <= CBC_LINK_OFF;
    end else if (wr_bus) begin
      link_q <= cbc_link_type'(
        reg_wdata[`CBC_BUS_LINK_MSB:`CBC_BUS_LINK_LSB]);
    end
  end

  // Registered read port, reserved bits zero
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= `CBC_RST_RDATA;
    end else if (reg_rd) begin
      case (reg_addr)
        `CBC_OFS_COMMAND: begin
          rdata_q <= {standby_q, rf_off_q, 1'b0, code_q};
        end
        `CBC_OFS_BUS_OWN: begin
          rdata_q <= {grant_write_unlock_q, host_port_bus_grant_q,
                      secure_module_bus_grant_q, 1'b0, link_q,
                      2'h0};
        end
        default: begin
          rdata_q <= 8'h00;               // Unmapped reads zero
        end
      endcase
    end
  end

  // Outputs straight from flops
  assign reg_rdata                 = rdata_q;
  assign chip_powerdown            = standby_q;
  assign rf_frontend_powerdown     = rf_off_q;
  assign cmd_code                  = code_q;
  assign cmd_start                 = start_q;
  assign cmd_busy                  = busy_q;
  assign host_if_enable            = host_port_bus_grant_q;
  assign sam_if_enable             = secure_module_bus_grant_q;
  assign secure_module_link_select = link_q;
endmodule

// ==== pkg/cbc_consts.svh ====
// Purpose: Offsets, field positions, reset values for command/bus control
// Assumes: Byte-wide register port, 7-bit register address
// Notes:   Included by the package and the cbc_top module
// How it works
// - Command bit 7 enters chip power-down
// - Command bit 6 powers down receiver, transmitter
// - Command bits 4:0 select running command
// - Command field cleared when command finishes
// - Unlock bit permits grant change next write
// - Next write after setting clears unlock
// - Host grant bit enables host interface
// - Module grant bit enables module interface
// - Both grant bits never set together
// - Host grant set only after prior unlock
// - Module grant set only after unlock
// - Bits 3:2 select secure-module link protocol
`ifndef CBC_CONSTS_SVH
`define CBC_CONSTS_SVH

// Register offsets
`define CBC_OFS_COMMAND      7'h00
`define CBC_OFS_BUS_OWN      7'h01

// Command register fields
`define CBC_CMD_STANDBY_BIT  7
`define CBC_CMD_RF_OFF_BIT   6
`define CBC_CMD_CODE_MSB     4
`define CBC_CMD_CODE_LSB     0
`define CBC_CMD_IDLE         5'h00

// Bus ownership register fields
`define CBC_BUS_UNLOCK_BIT   7
`define CBC_BUS_HOST_BIT     6
`define CBC_BUS_SAM_BIT      5
`define CBC_BUS_LINK_MSB     3
`define CBC_BUS_LINK_LSB     2

// Reset values
`define CBC_RST_COMMAND      8'h00
`define CBC_RST_BUS_OWN      8'h00
`define CBC_RST_RDATA        8'h00

`endif

// ==== pkg/cbc_pkg.sv ====
// Purpose: Types shared by the command and bus control modules
// Assumes: Constants come from cbc_consts.svh
// Notes:   One-hot state codes are written out
`include "cbc_consts.svh"
package cbc_pkg;
  // Command sequencer states, one-hot
  typedef enum logic [2:0] {
    CBC_ST_IDLE = 3'b001,
    CBC_ST_RUN  = 3'b010,
    CBC_ST_DONE = 3'b100
  } cbc_state_type;

  // Secure-module link protocol selection
  typedef enum logic [1:0] {
    CBC_LINK_OFF  = 2'h0,
    CBC_LINK_SPI  = 2'h1,
    CBC_LINK_LOW_SPEED_I2C_VARIANT = 2'h2,
    CBC_LINK_I2C  = 2'h3
  } cbc_link_type;

  // Command code width
  typedef logic [4:0] cbc_cmd_type;
endpackage

// ==== pkg/cbc_cmd_if.sv ====
// Purpose: Carrier between register bank and command sequencer
// Assumes: Single clock domain
// Notes:   start and finish are one-cycle pulses
`timescale 1ns/1ps
interface cbc_cmd_if;
  import cbc_pkg::*;
  logic        start;   // Launch a command
  logic        stop;    // Abort running command
  cbc_cmd_type code;    // Command code launched
  logic        busy;    // Sequencer is running
  logic        finish;  // Command has ended

  // Register bank side
  modport bank (output start, output stop, output code,
                input busy, input finish);
  // Sequencer side
  modport seq (input start, input stop, input code,
               output busy, output finish);
endinterface

// ==== core/cbc_cmd_seq.sv ====
// Purpose: Tracks one running command until it ends
// Assumes: cmd_done_in comes from logic on core_clk
// Notes:   finish pulses one cycle after done or stop
`timescale 1ns/1ps
module cbc_cmd_seq (
  input  wire logic core_clk,     // System clock
  input  wire logic reset_n,      // Async reset, active low
  input  wire logic cmd_done_in,  // Command engine reports completion
  cbc_cmd_if.seq    cmd           // Link to register bank
);
  import cbc_pkg::*;

  cbc_state_type state_q;         // Sequencer state

  // Sequencer state machine
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= CBC_ST_IDLE;
    end else begin
      case (state_q)
        CBC_ST_IDLE: begin
          // Launch on a non-idle code
          if (cmd.start) begin
            state_q <= CBC_ST_RUN;
          end
        end
        CBC_ST_RUN: begin
          // End on completion or abort
          if (cmd_done_in || cmd.stop) begin
            state_q <= CBC_ST_DONE;
          end
        end
        CBC_ST_DONE: begin
          // Back-to-back launch allowed
          state_q <= cmd.start ? CBC_ST_RUN : CBC_ST_IDLE;
        end
        default: begin
          state_q <= CBC_ST_IDLE;
        end
      endcase
    end
  end

  // Status toward the register bank
  assign cmd.busy   = (state_q == CBC_ST_RUN);
  assign cmd.finish = (state_q == CBC_ST_DONE);
endmodule

// ==== bench/cbc_assertions.sv ====
// Purpose: Port checks for command and bus ownership control
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to cbc_top after the module
`timescale 1ns/1ps
module cbc_assertions (
  input wire logic                  core_clk,  // Clock
  input wire logic                  reset_n,   // Reset, active low
  input wire logic [6:0]            reg_addr,  // Address
  input wire logic                  reg_wr,    // Write strobe
  input wire logic                  reg_rd,    // Read strobe
  input wire logic [7:0]            reg_wdata, // Write data
  input wire logic                  cmd_done_in, // Engine done
  input wire logic [7:0]            reg_rdata, // Read data
  input wire logic                  chip_powerdown, // Chip off
  input wire logic                  rf_frontend_powerdown, // Rx/Tx off
  input wire cbc_pkg::cbc_cmd_type  cmd_code,  // Command code
  input wire logic                  cmd_start, // Launch pulse
  input wire logic                  cmd_busy,  // Running
  input wire logic                  host_if_enable, // Host grant
  input wire logic                  sam_if_enable,  // Module grant
  input wire cbc_pkg::cbc_link_type secure_module_link_select // Link
);
  import cbc_pkg::*;
  logic       wr0;      // Write to command register
  logic       wr1;      // Write to bus ownership register
  logic [7:0] cmd_view; // Command register as read back
  assign wr0 = reg_wr && (reg_addr == 7'h00);
  assign wr1 = reg_wr && (reg_addr == 7'h01);
  assign cmd_view = {chip_powerdown, rf_frontend_powerdown, 1'b0, cmd_code};
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // Done during a run, no write in its way
  sequence s_fin;
    cmd_busy && cmd_done_in && !reg_wr ##1 !reg_wr;
  endsequence
  property p_pd;
    wr0 |=> chip_powerdown == $past(reg_wdata[7]);
  endproperty
  property p_rf;
    wr0 |=> rf_frontend_powerdown == $past(reg_wdata[6]);
  endproperty
  property p_start;
    wr0 && reg_wdata[4:0] != 5'h00
      |=> cmd_start && cmd_code == $past(reg_wdata[4:0]);
  endproperty
  property p_fin;
    s_fin |=> cmd_code == 5'h00;
  endproperty
  property p_excl;
    !(host_if_enable && sam_if_enable);
  endproperty
  property p_both;
    wr1 && reg_wdata[6:5] == 2'b11
      |=> $stable(host_if_enable) && $stable(sam_if_enable);
  endproperty
  property p_link;
    wr1 |=> secure_module_link_select == $past(reg_wdata[3:2]);
  endproperty
  property p_rd;
    reg_rd && !reg_wr && reg_addr == 7'h00 |=> reg_rdata == $past(cmd_view);
  endproperty
  a_pd: assert property (p_pd) else $error("power-down bit wrong");
  a_rf: assert property (p_rf) else $error("front-end bit wrong");
  a_start: assert property (p_start) else $error("launch wrong");
  a_fin: assert property (p_fin) else $error("code not cleared");
  a_excl: assert property (p_excl) else $error("both grants set");
  a_both: assert property (p_both) else $error("grant moved");
  a_link: assert property (p_link) else $error("link select wrong");
  a_rd: assert property (p_rd) else $error("read-back wrong");
endmodule
bind cbc_top cbc_assertions u_cbc_assertions (
  .core_clk, .reset_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
  .cmd_done_in, .reg_rdata, .chip_powerdown, .rf_frontend_powerdown,
  .cmd_code, .cmd_start, .cmd_busy, .host_if_enable, .sam_if_enable,
  .secure_module_link_select
);

// ==== bench/cbc_engine_model.sv ====
// Purpose: Behavioural command engine facing the block
// Assumes: Launch seen on the cmd_start pulse
// Notes:   slow picks a long run, else a short one
`timescale 1ns/1ps
module cbc_engine_model (
  input  wire logic core_clk,   // System clock
  input  wire logic reset_n,    // Async reset, active low
  input  wire logic cmd_start,  // Launch pulse
  input  wire logic slow,       // Long run time
  output logic      cmd_done_in // One-cycle done pulse
);
  int cnt; // Cycles left in the run
  // Count down from launch, pulse done at the end
  always @(negedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 0;
      cmd_done_in <= 1'b0;
    end else begin
      cmd_done_in <= (cnt == 1);
      if (cmd_start) cnt <= slow ? 20 : 4;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
endmodule

// ==== bench/command_and_bus_access_control_tb_top.sv ====
// Purpose: Self-checking bench for command and bus ownership control
// Assumes: Inputs driven at the falling edge
// Notes:   Integer model predicts every read and every port except cmd_start and cmd_busy
`timescale 1ns/1ps
module command_and_bus_access_control_tb_top;
  import cbc_pkg::*;
  logic core_clk, reset_n, reg_wr, reg_rd, cmd_done_in, slow;
  logic [6:0] reg_addr, ra;     // Address, random address
  logic [7:0] reg_wdata, rdat, reg_rdata;
  logic chip_powerdown, rf_frontend_powerdown, cmd_start, cmd_busy;
  logic host_if_enable, sam_if_enable;
  cbc_cmd_type cmd_code;
  cbc_link_type secure_module_link_select;
  logic [31:0] seed;            // Random state
  int fails, total_checks, m_pd, m_rf, m_cmd, m_unl, m_h, m_s, m_lnk;
  cbc_top u_cbc_top (.core_clk, .reset_n, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .cmd_done_in, .reg_rdata, .chip_powerdown,
    .rf_frontend_powerdown, .cmd_code, .cmd_start, .cmd_busy,
    .host_if_enable, .sam_if_enable, .secure_module_link_select);
  cbc_engine_model u_cbc_engine_model (.core_clk, .reset_n, .cmd_start,
    .slow, .cmd_done_in);
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (e !== g) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Expected read-back
  function logic [7:0] exp_reg(input logic [6:0] a);
    if (a == 7'h00) return {m_pd[0], m_rf[0], 1'b0, m_cmd[4:0]};
    if (a == 7'h01) return {m_unl[0], m_h[0], m_s[0], 1'b0, m_lnk[1:0], 2'b00};
    return 8'h00;
  endfunction
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    if (a == 7'h00) begin
      m_pd = d[7];
      m_rf = d[6];
      m_cmd = d[4:0];
    end
    if (a == 7'h01 && m_unl == 1 && !(d[6] && d[5])) begin
      m_h = d[6];
      m_s = d[5];
    end
    if (a == 7'h01) m_lnk = d[3:2];
    m_unl = (a == 7'h01 && m_unl == 0) ? d[7] : 0;
    chk("ports", {m_pd[0], m_rf[0], m_h[0], m_s[0], m_lnk[1:0], 2'b00},
      {chip_powerdown, rf_frontend_powerdown, host_if_enable,
       sam_if_enable, secure_module_link_select, 2'b00});
    chk("cmd_code", 8'(m_cmd), {3'b000, cmd_code});
  endtask
  task automatic rd(input logic [6:0] a);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    chk("reg_rdata", exp_reg(a), reg_rdata);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    print_verdict;
  end
  initial begin
    {reset_n, reg_wr, reg_rd, slow, reg_addr, reg_wdata} = '0;
    {fails, total_checks, m_pd, m_rf, m_cmd, m_unl, m_h, m_s, m_lnk} = '0;
    seed = 32'd77841;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk) reset_n = 1'b1;
    rd(7'h00);
    rd(7'h01);
    rd(7'h7f);
    $display("test reset done");
    wr(7'h01, 8'h40);
    wr(7'h01, 8'h80);
    rd(7'h01);
    wr(7'h01, 8'h60);
    wr(7'h01, 8'h80);
    wr(7'h01, 8'h40);
    wr(7'h01, 8'h80);
    wr(7'h05, 8'h00);
    wr(7'h01, 8'h20);
    wr(7'h01, 8'h80);
    rd(7'h01);
    wr(7'h01, 8'h20);
    rd(7'h01);
    $display("test grant done");
    for (int i = 0; i < 4; i++) wr(7'h01, 8'(i << 2));
    wr(7'h00, 8'hc0);
    wr(7'h00, 8'h40);
    wr(7'h00, 8'h80);
    $display("test mode done");
    for (int s = 0; s < 3; s++) begin
      slow = (s > 0);
      wr(7'h00, 8'(5 + s));
      rd(7'h00);
      chk("cmd_busy", 8'h01, {7'b0, cmd_busy});
      if (s == 2) wr(7'h00, 8'h00);
      for (int k = 0; k < 60 && (k < 4 || cmd_busy !== 1'b0); k++)
        @(negedge core_clk);
      chk("cmd_busy", 8'h00, {7'b0, cmd_busy});
      m_cmd = 0;
      rd(7'h00);
    end
    $display("test command done");
    for (int i = 0; i < 200; i++) begin
      seed = lfsr(seed);
      ra = {5'b0, seed[1:0]};
      rdat = seed[15:8];
      if (ra == 7'h00) rdat[4:0] = 5'h00;
      wr(ra, rdat);
      rd({5'b0, seed[17:16]});
    end
    $display("test random done");
    print_verdict;
  end
endmodule
